// *** logic/stc_pkg.sv ***
// Constants and types shared by the serial transmit and reset control block
package stc_pkg;

  // Core data-memory addresses of the interface registers
  localparam logic [15:0] ADDR_CTRL     = 16'hFFF0;
  localparam logic [15:0] ADDR_STAT     = 16'hFFF1;
  localparam logic [15:0] ADDR_CLKC     = 16'hFFF2;
  localparam logic [15:0] ADDR_TX_MARK  = 16'hFFF3;
  localparam logic [15:0] ADDR_TX_LOW   = 16'hFFF4;
  localparam logic [15:0] ADDR_TX_MID   = 16'hFFF5;
  localparam logic [15:0] ADDR_TX_HIGH  = 16'hFFF6;

  // Field positions in interface_control
  localparam int CTRL_WDS_LSB   = 0;
  localparam int CTRL_BIT_ORDER = 3;
  localparam int CTRL_BREAK     = 4;
  localparam int CTRL_TX_EN     = 9;
  localparam int CTRL_TX_IRQ_EN = 12;
  localparam int CTRL_CLK_POL   = 15;
  // Field positions in serial_clock_control and serial_status
  localparam int CLKC_TX_SRC    = 15;
  localparam int STAT_TX_HOLD_E = 1;
  localparam int STAT_TX_SHF_E  = 0;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CLKC_RST = 16'h0000;

  // Word formats selected by word_format_select
  localparam logic [2:0] WDS_SYNC    = 3'h0;
  localparam logic [2:0] WDS_ASYNC10 = 3'h2;
  localparam logic [2:0] WDS_MDROP11 = 3'h4;
  localparam logic [2:0] WDS_EVEN11  = 3'h6;
  localparam logic [2:0] WDS_ODD11   = 3'h7;

  // Frame lengths in bits and the lead-in before the first bit
  localparam logic [3:0] LEN_SYNC    = 4'h8;
  localparam logic [3:0] LEN_ASYNC10 = 4'hA;
  localparam logic [3:0] LEN_ASYNC11 = 4'hB;
  // Three ticks keep at least two whole bit periods before the first bit, whatever the hand-off phase
  localparam logic [1:0] LEAD_BITS   = 2'h3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [23:0] wdata;
  } stc_bus_req_s;

  typedef struct packed {
    logic       mark;
    logic [7:0] data;
  } stc_txword_s;

  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SHIFT} stc_tx_e;

endpackage

// *** logic/stc_top.sv ***
// Serial transmit path, reset control and echo FIFO
//
// Function
// [RL1] Writes to low, middle, high transmit addresses load bus byte 0, 1, 2.
// [RL2] Multidrop mode: address-marked write stores low byte and sets the address bit.
// [RL3] Multidrop mode: plain transmit writes clear the address bit.
// [RL4] Any transmit holding write clears the holding-empty flag.
// [RL5] Holding contents move to the shifter only once the shifter is empty.
// [RL6] Two to four bit periods pass between hand-off and the first bit.
// [RL7] A second write before hand-off overwrites; software polls the empty flag.
// [RL8] Transmit interrupt only while the holding-empty flag is one.
// [RL9] Shifter is not addressable; its emptiness shows only in a status bit.
// [RL10] Synchronous bits follow the transmit clock, internal or external per source bit.
// [RL11] Async frame: start, eight data bits in selected order, ninth bit, stop.
// [RL12] Synchronous byte goes LSB first at polarity zero, MSB first at one.
// [RL13] Synchronous mode accepts data from any plain transmit address.
// [RL14] After a character: preamble first, then break, then pending data.
// [RL15] Block stays in reset while all pin-function bits are zero.
// [RL16] Clearing pin-function bits stops activity, resets status, keeps control register.
// [RL17] Stop halts the block and resets status, other registers kept.
// [RL18] Software resets, programs control registers, then selects pins.
// [RL19] With interrupts, operation needs pins selected and interrupt enabled, any order.
// [RL20] Receive shifter is invisible; only receive holding byte is readable.
// [RL21] Holding-empty interrupt is gated by control bit 12.
// [RL22] Word format zero selects synchronous shift-register mode.
// [RL23] Preamble is one all-ones frame, break one all-zeros frame.
`timescale 1ns/1ps
`default_nettype none

module stc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      cnt;
  logic [AW:0]      next_cnt;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("stc_fifo: DEPTH must be a power of two, at least 2");
  end

  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_idx];

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) next_cnt = cnt + 1'b1;
    else if (pop && !push) next_cnt = cnt - 1'b1;
  end

  always_ff @(posedge i_mclk) begin
    if (push) mem[wr_idx] <= i_in_data;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_idx      <= '0;
      rd_idx      <= '0;
      cnt         <= '0;
      o_out_valid <= 1'b0;
      o_in_ready  <= 1'b1;
    end else begin
      if (push) wr_idx <= wr_idx + 1'b1;
      if (pop) rd_idx <= rd_idx + 1'b1;
      cnt         <= next_cnt;
      // Flags registered so the top can hand them straight out
      o_out_valid <= (next_cnt != '0);
      o_in_ready  <= (next_cnt != (AW + 1)'(DEPTH));
    end
  end
endmodule // stc_fifo

module stc_top #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_sw_reset,
  input  wire logic                 i_stop,
  input  wire logic [2:0]           i_pin_func_sel,
  input  wire stc_pkg::stc_bus_req_s i_bus,
  output logic [23:0]               o_rdata,
  input  wire logic [7:0]           i_rx_holding_byte,
  input  wire logic                 i_int_bit_tick,
  input  wire logic                 i_sclk,
  output logic                      o_txd,
  output logic                      o_tx_irq,
  output logic                      o_active,
  output logic                      o_echo_valid,
  input  wire logic                 i_echo_ready,
  output stc_pkg::stc_txword_s      o_echo_word
);
  import stc_pkg::*;

  initial begin
    if (FIFO_DEPTH < 2) $error("stc_top: FIFO_DEPTH too small");
  end

  logic [15:0] interface_control;
  logic [15:0] serial_clock_control;
  logic [7:0]  hold_data;
  logic        hold_mark;
  logic        tx_holding_empty;
  logic        pre_pend;
  logic        te_q;
  logic        sclk_s1, sclk_s2, sclk_s3;
  stc_tx_e     state;
  logic [10:0] shreg;
  logic [3:0]  bits_left;
  logic [1:0]  lead_cnt;
  logic        fifo_ready;

  logic        active, halt, bit_tick, wr_any, wr_plain, wr_mark;
  logic        is_sync, has_ninth, order_msb, ninth;
  logic [2:0]  fmt;
  logic [3:0]  frame_len;
  logic [7:0]  data_ord;
  logic [10:0] data_frame;
  logic        at_idle, te_rise, start_pre, start_brk, start_data;

  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = d[7-i];
    return r;
  endfunction

  // Pin selection releases the block; stop or software reset hold it
  assign active = (|i_pin_func_sel) && !i_stop;                           // [RL15] [RL17]
  assign halt   = !active || i_sw_reset;                                  // [RL16] [RL17]

  // Only the second and third flops are looked at; the first may be metastable
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
    end else begin
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
    end
  end
  assign bit_tick = serial_clock_control[CLKC_TX_SRC] ? (sclk_s2 && !sclk_s3) : i_int_bit_tick; // [RL10]

  assign wr_plain = i_bus.wr && (i_bus.addr inside {ADDR_TX_LOW, ADDR_TX_MID, ADDR_TX_HIGH}); // [RL13]
  assign wr_mark  = i_bus.wr && (i_bus.addr == ADDR_TX_MARK);
  assign wr_any   = (wr_plain || wr_mark) && !halt;

  // Control registers survive individual and stop resets, only hw/sw reset clears them
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      interface_control    <= CTRL_RST;
      serial_clock_control <= CLKC_RST;
    end else if (i_sw_reset) begin
      interface_control    <= CTRL_RST;
      serial_clock_control <= CLKC_RST;
    end else if (i_bus.wr) begin
      if (i_bus.addr == ADDR_CTRL) interface_control <= i_bus.wdata[15:0];  // [RL16]
      if (i_bus.addr == ADDR_CLKC) serial_clock_control <= i_bus.wdata[15:0];
    end
  end

  // Single holding byte; a later write simply overwrites it
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_data <= 8'h00;
      hold_mark <= 1'b0;
    end else if (wr_any) begin                                            // [RL7]
      hold_mark <= wr_mark;                                               // [RL2] [RL3]
      case (i_bus.addr)
        ADDR_TX_MID:  hold_data <= i_bus.wdata[15:8];                     // [RL1]
        ADDR_TX_HIGH: hold_data <= i_bus.wdata[23:16];                    // [RL1]
        default:      hold_data <= i_bus.wdata[7:0];                      // [RL1] [RL2]
      endcase
    end
  end

  // Frame assembly
  assign fmt       = interface_control[CTRL_WDS_LSB +: 3];
  assign is_sync   = (fmt == WDS_SYNC);                                   // [RL22]
  assign has_ninth = (fmt == WDS_MDROP11) || (fmt == WDS_EVEN11) || (fmt == WDS_ODD11);
  assign frame_len = is_sync ? LEN_SYNC : (has_ninth ? LEN_ASYNC11 : LEN_ASYNC10);
  assign order_msb = is_sync ? interface_control[CTRL_CLK_POL] : interface_control[CTRL_BIT_ORDER]; // [RL11] [RL12]
  assign data_ord  = order_msb ? rev8(hold_data) : hold_data;
  always_comb begin
    case (fmt)
      WDS_EVEN11: ninth = ^hold_data;
      WDS_ODD11:  ninth = ~^hold_data;
      default:    ninth = hold_mark;
    endcase
  end
  // Sent from bit 0 upward: start, data, ninth bit, stop
  assign data_frame = is_sync ? {3'h0, data_ord} :
                      (has_ninth ? {1'b1, ninth, data_ord, 1'b0} : {2'b11, data_ord, 1'b0}); // [RL11]

  // A toggle seen this cycle counts as pending, so a break set by the same write waits behind it
  assign te_rise    = interface_control[CTRL_TX_EN] && !te_q;
  // A hand-off waits a cycle if the core writes in the same cycle
  assign at_idle    = (state == TX_IDLE) && !halt;                        // [RL5]
  assign start_pre  = at_idle && (pre_pend || te_rise);                   // [RL14]
  assign start_brk  = at_idle && !pre_pend && !te_rise && interface_control[CTRL_BREAK]; // [RL14]
  assign start_data = at_idle && !pre_pend && !te_rise && !interface_control[CTRL_BREAK] &&
                      !tx_holding_empty && interface_control[CTRL_TX_EN] && fifo_ready && !wr_any; // [RL14] [RL5]

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_holding_empty <= 1'b1;
    end else if (halt) begin
      tx_holding_empty <= 1'b1;                                           // [RL16] [RL17]
    end else if (wr_any) begin
      tx_holding_empty <= 1'b0;                                           // [RL4]
    end else if (start_data) begin
      tx_holding_empty <= 1'b1;
    end
  end

  // Turning the transmitter on queues one preamble; a new toggle seen while one is taken stays queued
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      te_q     <= 1'b0;
      pre_pend <= 1'b0;
    end else begin
      te_q <= interface_control[CTRL_TX_EN];
      if (halt) pre_pend <= 1'b0;
      else if (start_pre) pre_pend <= pre_pend && te_rise;                // [RL14]
      else if (te_rise) pre_pend <= 1'b1;                                 // [RL14]
    end
  end

  // Shifter: load, lead-in of LEAD_BITS ticks, then one bit per tick
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state     <= TX_IDLE;
      shreg     <= 11'h7FF;
      bits_left <= 4'h0;
      lead_cnt  <= 2'h0;
      o_txd     <= 1'b1;
    end else if (halt) begin
      state <= TX_IDLE;                                                   // [RL16] [RL17]
      o_txd <= 1'b1;
    end else begin
      case (state)
        TX_IDLE: begin
          if (start_pre || start_brk || start_data) begin
            state     <= TX_LEAD;
            lead_cnt  <= 2'h0;
            bits_left <= frame_len;
            shreg     <= start_pre ? 11'h7FF : (start_brk ? 11'h000 : data_frame); // [RL23]
          end
        end
        TX_LEAD: begin
          if (bit_tick) begin
            lead_cnt <= lead_cnt + 2'h1;
            if (lead_cnt == LEAD_BITS - 2'h1) begin                        // [RL6]
              state <= TX_SHIFT;
              o_txd <= shreg[0];
            end
          end
        end
        TX_SHIFT: begin
          if (bit_tick) begin                                             // [RL10]
            if (bits_left == 4'h1) begin
              state <= TX_IDLE;
              o_txd <= 1'b1;
            end else begin
              shreg     <= {1'b1, shreg[10:1]};
              o_txd     <= shreg[1];
              bits_left <= bits_left - 4'h1;
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // Every data word handed to the shifter is echoed; a full FIFO stalls hand-off
  stc_fifo #(
    .WIDTH ($bits(stc_txword_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_echo (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (start_data),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({hold_mark, hold_data}),
    .o_out_valid (o_echo_valid),
    .i_out_ready (i_echo_ready),
    .o_out_data  (o_echo_word)
  );

  // Shifter emptiness is visible only as a status bit
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata  <= 24'h000000;
      o_tx_irq <= 1'b0;
      o_active <= 1'b0;
    end else begin
      o_tx_irq <= tx_holding_empty && interface_control[CTRL_TX_IRQ_EN] && active; // [RL8] [RL21] [RL19]
      o_active <= active;
      if (i_bus.rd) begin
        case (i_bus.addr)
          ADDR_CTRL:    o_rdata <= {8'h00, interface_control};
          ADDR_STAT:    o_rdata <= {22'h0, tx_holding_empty, state == TX_IDLE}; // [RL9]
          ADDR_CLKC:    o_rdata <= {8'h00, serial_clock_control};
          ADDR_TX_LOW:  o_rdata <= {16'h0000, i_rx_holding_byte};        // [RL20]
          ADDR_TX_MID:  o_rdata <= {8'h00, i_rx_holding_byte, 8'h00};    // [RL20]
          ADDR_TX_HIGH: o_rdata <= {i_rx_holding_byte, 16'h0000};        // [RL20]
          default:      o_rdata <= 24'h000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_hold_empty_clear: assert property (wr_any |=> !tx_holding_empty)     // [RL4]
    else $error("holding-empty flag not cleared by write");
  a_mid_byte_load: assert property (wr_any && i_bus.addr == ADDR_TX_MID |=> hold_data == $past(i_bus.wdata[15:8])) // [RL1]
    else $error("middle byte not loaded");
  a_mark_bit_set: assert property (wr_any && wr_mark |=> hold_mark)     // [RL2]
    else $error("address bit not set");
  a_mark_bit_clear: assert property (wr_any && wr_plain |=> !hold_mark) // [RL3]
    else $error("address bit not cleared");
  a_handoff_when_empty: assert property (start_data |-> state == TX_IDLE ##1 state == TX_LEAD && tx_holding_empty) // [RL5]
    else $error("hand-off while shifter busy");
  a_lead_ticks: assert property ($rose(state == TX_SHIFT) |-> $past(bit_tick && lead_cnt == LEAD_BITS - 2'h1)) // [RL6]
    else $error("first bit not after the full lead-in");
  a_irq_gate: assert property (o_tx_irq |-> $past(tx_holding_empty && interface_control[CTRL_TX_IRQ_EN])) // [RL8]
    else $error("transmit interrupt without empty flag");
  a_txd_on_tick: assert property (!halt && $past(!halt) && $changed(o_txd) |-> $past(bit_tick)) // [RL10]
    else $error("serial output changed off a bit tick");
  a_pre_first: assert property (start_brk || start_data |-> !pre_pend && !te_rise)   // [RL14]
    else $error("preamble not served first");
  a_reset_state: assert property (!active |=> tx_holding_empty && state == TX_IDLE && o_txd) // [RL15] [RL16]
    else $error("status not reset while inactive");
  a_ctrl_kept: assert property (!active && !i_sw_reset && !i_bus.wr |=> $stable(interface_control)) // [RL16]
    else $error("control register changed by individual reset");

  c_preamble: cover property (start_pre);
  c_break: cover property (start_brk);
  c_data_frame: cover property (start_data ##[1:300] state == TX_SHIFT);
  c_fifo_stall: cover property (at_idle && !tx_holding_empty && !fifo_ready);
endmodule // stc_top

`default_nettype wire

// *** test/stc_peer.sv ***
// Far-side serial peer: supplies an external bit clock and captures frames from the transmit line
`timescale 1ns/1ps
`default_nettype none

module stc_peer (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic [2:0]  i_phase,
  input  wire logic        i_ext,
  input  wire logic        i_flush,
  input  wire logic [3:0]  i_len,
  input  wire logic        i_txd,
  output logic             o_sclk,
  output logic             o_busy,
  output logic             o_frame_valid,
  output logic [10:0]      o_frame
);
  logic [3:0] cnt;

  // Clock stands low unless this side asks for bits
  assign o_sclk = i_ext & (i_phase < 3'h4);

  // Sample late in the bit period so the sender's synchroniser delay is covered
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 4'h0;
      o_busy <= 1'b0;
      o_frame_valid <= 1'b0;
      o_frame <= 11'h000;
    end else begin
      o_frame_valid <= 1'b0;
      if (i_flush) begin
        cnt <= 4'h0;
        o_busy <= 1'b0;
      end else if (i_phase == 3'h6 && (o_busy || !i_txd)) begin
        o_frame <= o_busy ? {o_frame[9:0], i_txd} : {10'h000, i_txd};
        o_busy <= (cnt + 4'h1 != i_len);
        cnt <= (cnt + 4'h1 == i_len) ? 4'h0 : cnt + 4'h1;
        o_frame_valid <= (cnt + 4'h1 == i_len);
      end
    end
  end
endmodule  // stc_peer

`default_nettype wire

// *** test/stc_top_tb.sv ***
// Self-checking testbench for the serial transmit and reset control block
`timescale 1ns/1ps
`default_nettype none

module stc_top_tb;
  import stc_pkg::*;

  logic         mclk = 1'b0, rst_b = 1'b0, sw_reset = 1'b0, stop = 1'b0, echo_ready = 1'b0;
  logic         ext = 1'b0, flush = 1'b0, rnd_ready = 1'b1, o = 1'b0;
  logic [2:0]   pin_sel = 3'h0, ph = 3'h0, m = 3'h0;
  logic [7:0]   rx = 8'h00;
  logic [3:0]   len = 4'hA;
  logic [15:0]  ctrl;
  stc_bus_req_s bus = '0;
  logic [23:0]  rdata;
  logic         txd, irq, active, echo_valid, sclk, busy, fval;
  stc_txword_s  echo_word;
  logic [10:0]  frame;
  int           seed = 36, mismatches = 0, compares = 0, cycles = 0;
  logic [10:0]  fq[$];
  stc_txword_s  eq[$];
  logic [2:0]   modes [5] = '{WDS_SYNC, WDS_ASYNC10, WDS_MDROP11, WDS_EVEN11, WDS_ODD11};
  logic [15:0]  addrs [3] = '{ADDR_TX_LOW, ADDR_TX_MID, ADDR_TX_HIGH};

  stc_top #(.FIFO_DEPTH(32)) dut (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_sw_reset(sw_reset), .i_stop(stop), .i_pin_func_sel(pin_sel),
    .i_bus(bus), .o_rdata(rdata), .i_rx_holding_byte(rx), .i_int_bit_tick(ph == 3'h0), .i_sclk(sclk),
    .o_txd(txd), .o_tx_irq(irq), .o_active(active), .o_echo_valid(echo_valid),
    .i_echo_ready(echo_ready), .o_echo_word(echo_word));

  stc_peer peer (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_phase(ph), .i_ext(ext), .i_flush(flush), .i_len(len),
    .i_txd(txd), .o_sclk(sclk), .o_busy(busy), .o_frame_valid(fval), .o_frame(frame));

  always #4 mclk = ~mclk;

  // Bit ticks every eight cycles; the echo side stalls at random
  always @(negedge mclk) begin
    ph <= ph + 3'h1;
    echo_ready <= rnd_ready && ($random(seed) % 2 != 0);
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      tally(1'b0, "timeout");
      conclude();
    end
  end

  task automatic tally(input logic ok, input string what);
    compares++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [23:0] g, input logic [23:0] e);
    tally(g === e, $sformatf("register read %h expected %h", g, e));
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    tally(g === e, $sformatf("flag %b expected %b", g, e));
  endtask
  task automatic cmp_frame(input logic [10:0] g, input logic [10:0] e);
    tally(g === e, $sformatf("frame %h expected %h", g, e));
  endtask
  task automatic cmp_echo(input stc_txword_s g, input stc_txword_s e);
    tally(g === e, $sformatf("echo %h expected %h", g, e));
  endtask

  // Frame as the peer sees it: first bit on the line is the most significant
  function automatic logic [10:0] fexp(input logic [7:0] d, input logic mk);
    logic [10:0] f;
    logic        rev;
    f = 11'h000;
    rev = (m == WDS_SYNC) ? o : o;
    if (m != WDS_SYNC) f = {f[9:0], 1'b0};
    for (int i = 0; i < 8; i++) f = {f[9:0], rev ? d[7 - i] : d[i]};
    if (m == WDS_MDROP11) f = {f[9:0], mk};
    if (m == WDS_EVEN11) f = {f[9:0], ^d};
    if (m == WDS_ODD11) f = {f[9:0], ~^d};
    if (m != WDS_SYNC) f = {f[9:0], 1'b1};
    return f;
  endfunction

  // Synchronous bytes keep their first bit low so the peer can find the frame
  function automatic logic [7:0] pick();
    return 8'($random(seed)) & ((m == WDS_SYNC) ? 8'h7E : 8'hFF);
  endfunction

  always @(posedge mclk) begin
    if (fval) begin
      if (fq.size() == 0) tally(1'b0, "unexpected frame");
      else cmp_frame(frame, fq.pop_front());
    end
    if (echo_valid && echo_ready) begin
      if (eq.size() == 0) tally(1'b0, "unexpected echo");
      else cmp_echo(echo_word, eq.pop_front());
    end
  end

  task automatic wr(input logic [15:0] a, input logic [23:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    bus <= '0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [23:0] e);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
    @(negedge mclk);
    bus <= '0;
    @(negedge mclk);
    cmp_reg(rdata, e);
  endtask
  task automatic mode(input logic [2:0] mm, input logic oo);
    m = mm;
    o = oo;
    len = (mm == WDS_SYNC) ? LEN_SYNC : (mm == WDS_ASYNC10) ? LEN_ASYNC10 : LEN_ASYNC11;
    ctrl = {oo, 2'b00, 1'b1, 2'b00, 1'b1, 5'h00, oo, mm};
    wr(ADDR_CTRL, {8'h00, ctrl});
  endtask
  task automatic send(input logic [15:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = 24'($random(seed));
    if (a == ADDR_TX_MID) w[15:8] = d;
    else if (a == ADDR_TX_HIGH) w[23:16] = d;
    else w[7:0] = d;
    fq.push_back(fexp(d, a == ADDR_TX_MARK));
    eq.push_back('{mark: a == ADDR_TX_MARK, data: d});
    wr(a, w);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && (fq.size() != 0 || busy || (rnd_ready && eq.size() != 0)); i++)
      @(negedge mclk);
    if (fq.size() != 0 || busy || (rnd_ready && eq.size() != 0)) tally(1'b0, "frame wait ran out");
    repeat (16) @(negedge mclk);
  endtask
  task automatic wait_busy();
    for (int i = 0; i < 400 && !busy; i++) @(negedge mclk);
    if (!busy) tally(1'b0, "peer never started a frame");
  endtask

  initial begin
    rx = 8'($random(seed));
    repeat (2) @(negedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    rd(ADDR_CTRL, 24'h000000);
    rd(ADDR_CLKC, 24'h000000);
    rd(16'hFFF7, 24'h000000);
    wr(ADDR_STAT, 24'h000000);
    wr(ADDR_TX_LOW, 24'h000055);
    rd(ADDR_STAT, 24'h000003);
    rd(ADDR_TX_MID, {8'h00, rx, 8'h00});
    mode(WDS_ASYNC10, 1'b0);
    wr(ADDR_CLKC, 24'h000000);
    pin_sel <= 3'h4;
    repeat (3) @(negedge mclk);
    cmp_flag(active, 1'b1);
    cmp_flag(irq, 1'b1);
    for (int k = 0; k < 10; k++) begin
      mode(modes[k % 5], k > 4);
      send(addrs[k % 3], pick());
      wait_done();
      if (m == WDS_MDROP11) begin
        send(ADDR_TX_MARK, pick());
        wait_done();
        send(ADDR_TX_HIGH, pick());
        wait_done();
      end
    end
    mode(WDS_ASYNC10, 1'b0);
    send(ADDR_TX_LOW, pick());
    repeat (4) @(negedge mclk);
    rd(ADDR_STAT, 24'h000002);
    wr(ADDR_TX_LOW, 24'h0000B1);
    send(ADDR_TX_LOW, pick());
    rd(ADDR_STAT, 24'h000000);
    cmp_flag(irq, 1'b0);
    wait_done();
    rd(ADDR_STAT, 24'h000003);
    wr(ADDR_CTRL, 24'h000002);
    cmp_flag(irq, 1'b0);
    wr(ADDR_CTRL, 24'h001212);
    fq.push_back(11'h000);
    send(ADDR_TX_LOW, pick());
    repeat (60) @(negedge mclk);
    cmp_flag(busy, 1'b0);
    wait_busy();
    wr(ADDR_CTRL, {8'h00, ctrl});
    wait_done();
    wr(ADDR_CLKC, 24'h008000);
    mode(WDS_SYNC, 1'b1);
    send(ADDR_TX_LOW, pick());
    repeat (80) @(negedge mclk);
    cmp_flag(busy, 1'b0);
    ext <= 1'b1;
    wait_done();
    ext <= 1'b0;
    wr(ADDR_CLKC, 24'h000000);
    mode(WDS_ASYNC10, 1'b0);
    for (int j = 0; j < 2; j++) begin
      send(ADDR_TX_LOW, pick());
      void'(fq.pop_back());
      wait_busy();
      if (j == 0) stop <= 1'b1;
      else pin_sel <= 3'h0;
      repeat (3) @(negedge mclk);
      flush <= 1'b1;
      cmp_flag(txd, 1'b1);
      cmp_flag(active, 1'b0);
      rd(ADDR_STAT, 24'h000003);
      rd(ADDR_CTRL, {8'h00, ctrl});
      stop <= 1'b0;
      pin_sel <= 3'h4;
      flush <= 1'b0;
      wait_done();
    end
    rnd_ready <= 1'b0;
    mode(WDS_SYNC, 1'b0);
    for (int n = 0; n < 32; n++) begin
      send(ADDR_TX_LOW, pick());
      wait_done();
    end
    send(ADDR_TX_LOW, pick());
    repeat (120) @(negedge mclk);
    rd(ADDR_STAT, 24'h000001);
    rnd_ready <= 1'b1;
    wait_done();
    sw_reset <= 1'b1;
    @(negedge mclk);
    sw_reset <= 1'b0;
    rd(ADDR_CTRL, 24'h000000);
    rd(ADDR_STAT, 24'h000003);
    conclude();
  end
endmodule  // stc_top_tb

`default_nettype wire
